// *** pkg/iprc_pkg.sv ***
// Purpose: shared constants and types for the interrupt pin routing block
// Assumes: plain register port, one 100 MHz clock
// Notes:   offsets are register byte offsets inside the configuration space
package iprc_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [15:0] OFS_DEV30_ROUTE = 16'h3142;
	localparam logic [15:0] OFS_DEV29_ROUTE = 16'h3144;
	localparam logic [15:0] OFS_DEV28_ROUTE = 16'h3146;
	localparam logic [15:0] OFS_DEV27_ROUTE = 16'h3148;
	localparam logic [15:0] OFS_DEV26_ROUTE = 16'h314c;
	localparam logic [15:0] OFS_DEV25_ROUTE = 16'h3150;
	localparam logic [15:0] OFS_DEV31_ROUTE = 16'h3140;
	localparam logic [15:0] OFS_OTHER_CTRL  = 16'h31ff;
	localparam logic [15:0] OFS_C3_LATENCY  = 16'h3300;
	localparam logic [15:0] OFS_EVT_STATUS  = 16'h3380;
	localparam logic [15:0] OFS_EVT_MASK    = 16'h3384;
	localparam logic [15:0] OFS_FLOAT_ERROR_IN_CLEAR  = 16'h00f0;

	// ------------------------------------------------------------
	// field layouts and reset values
	// ------------------------------------------------------------
	localparam int          NUM_DEV         = 6;
	localparam int          NUM_PIN         = 4;
	localparam int          NUM_LINE        = 8;
	localparam int          ROUTE_W         = 3;
	localparam int          ROUTE_STRIDE    = 4;
	localparam logic [15:0] ROUTE_RESET     = 16'h3210;
	localparam logic [15:0] ROUTE_MASK      = 16'h7777;
	localparam logic [7:0]  OTHER_RESET     = 8'h00;
	localparam logic [7:0]  OTHER_MASK      = 8'hf3;
	localparam int          OTHER_AEN_BIT   = 0;
	localparam int          OTHER_CEN_BIT   = 1;
	localparam int          OTHER_SEL_LSB   = 4;
	localparam logic [31:0] LAT_RESET       = 32'h0000_0000;
	localparam logic [31:0] LAT_MASK        = 32'h007f_7f7f;
	localparam int          NUM_EVT         = 2;
	localparam int          EVT_FLOAT_ERROR_IN        = 0;
	localparam int          EVT_CFG_CHANGE  = 1;
	localparam int          SYNC_STAGES     = 3;

	typedef logic [15:0] iprc_route_t;
endpackage

// *** pkg/iprc_pin_if.sv ***
// Purpose: carries the per-device pin levels and route codes into the line combiner
// Assumes: all signals in the main clock domain
// Notes:   one route word per device, four pins per device
`timescale 1ns/1ps
interface iprc_pin_if;
	import iprc_pkg::*;
	logic [NUM_DEV*NUM_PIN-1:0] pin_level;
	logic [NUM_DEV*16-1:0]      route_word;
	logic [NUM_LINE-1:0]        line_level;
	modport src (output pin_level, output route_word, input line_level);
	modport comb (input pin_level, input route_word, output line_level);
endinterface

// *** hw/iprc_line_merge.sv ***
// Purpose: merges every routed device pin onto the eight shared request lines
// Assumes: pin levels active high, already synchronised
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/1ps
module iprc_line_merge
	import iprc_pkg::*;
(
	iprc_pin_if.comb pins
);
	// ------------------------------------------------------------
	// one or-plane per shared line
	// ------------------------------------------------------------
	genvar l;
	generate
		for (l = 0; l < NUM_LINE; l++) begin : g_line
			logic hit;
			// any pin whose route code names this line drives it
			always_comb begin
				hit = 1'b0;
				for (int d = 0; d < NUM_DEV; d++) begin
					for (int p = 0; p < NUM_PIN; p++) begin
						if (pins.pin_level[d*NUM_PIN+p] &&
						    pins.route_word[d*16+p*ROUTE_STRIDE +: ROUTE_W] == ROUTE_W'(l)) begin
							hit = 1'b1;
						end
					end
				end
			end
			assign pins.line_level[l] = hit;
		end
	endgenerate
endmodule

// *** hw/iprc_top.sv ***
// Purpose: interrupt pin routing and other interrupt control registers
// Assumes: synchronous active-high reset, one-cycle register strobes
// Notes:   shared lines leave active high; the pad inverts them
//
// Behaviour
// - each 3-bit route code 0..7 picks one of eight shared request lines.
// - route fields sit at bits 2:0, 6:4, 10:8, 14:12; others reserved.
// - writable route registers reset to 3210h.
// - device 30 route register is read-only zero.
// - devices 25..29 and 31 each own a separate route register.
// - bits 7:4 of other control give interrupt controller address bits 15:12.
// - coprocessor error enable clear blocks interrupt 13 and ignore-error output.
// - enabled and float error low raises interrupt 13 until port F0h write.
// - bit 0 enables the I/O interrupt controller and its address decode.
// - C3 latency register holds three 7-bit fields at 6:0, 14:8, 22:16.
`timescale 1ns/1ps
module iprc_top
	import iprc_pkg::*;
(
	input  wire logic                       REF_CLK,
	input  wire logic                       RST,
	input  wire logic [15:0]                REG_ADDR,
	input  wire logic [31:0]                REG_WDATA,
	input  wire logic                       REG_WR,
	input  wire logic                       REG_RD,
	output logic      [31:0]                REG_RDATA,
	input  wire logic [NUM_DEV*NUM_PIN-1:0] DEV_PIN_IN,
	input  wire logic                       FLOAT_ERROR_IN_N,
	output logic      [NUM_LINE-1:0]        SHARED_REQ_LINE,
	output logic                            IRQ13_OUT,
	output logic                            IGNORE_NUMERIC_ERROR_OUT_N,
	output logic                            IO_INTC_ENABLE,
	output logic      [3:0]                 APIC_WINDOW_SELECT,
	output logic      [6:0]                 LAT_C0_TO_C3,
	output logic      [6:0]                 LAT_C2_TO_C3,
	output logic      [6:0]                 LAT_C3_TO_C3,
	output logic                            INTERRUPT
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		iprc_route_t [NUM_DEV-1:0]     route;
		logic [7:0]                    other;
		logic [31:0]                   lat;
		logic                          irq13;
		logic [2:0]                    float_error_in_sync;
		logic                          float_error_in_seen;
		logic [NUM_EVT-1:0]            status;
		logic [NUM_EVT-1:0]            mask;
		logic [NUM_LINE-1:0]           lines;
		logic [31:0]                   rdata;
	} iprc_state_t;

	iprc_state_t state_r;
	iprc_state_t state_nxt;

	iprc_pin_if pins ();

	// route register index order: dev25, 26, 27, 28, 29, 31
	localparam logic [15:0] ROUTE_OFS [NUM_DEV] = '{OFS_DEV25_ROUTE, OFS_DEV26_ROUTE,
		OFS_DEV27_ROUTE, OFS_DEV28_ROUTE, OFS_DEV29_ROUTE, OFS_DEV31_ROUTE};

	// ------------------------------------------------------------
	// pin fabric
	// ------------------------------------------------------------
	// device pins come from same-clock logic, no synchroniser needed
	assign pins.pin_level  = DEV_PIN_IN;
	assign pins.route_word = state_r.route;

	iprc_line_merge u_merge (
		.pins (pins.comb)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic float_error_in_low;
		logic f0_write;
		logic [NUM_EVT-1:0] evt;
		float_error_in_low  = 1'b0;
		f0_write  = 1'b0;
		evt       = '0;
		state_nxt = state_r;

		// float error pin is asynchronous: three flops, act when last two agree
		state_nxt.float_error_in_sync = {state_r.float_error_in_sync[1:0], FLOAT_ERROR_IN_N};
		if (state_r.float_error_in_sync[2] == state_r.float_error_in_sync[1]) begin
			state_nxt.float_error_in_seen = ~state_r.float_error_in_sync[2];
		end
		float_error_in_low = state_r.float_error_in_seen;

		// shared lines registered so data outputs come from flops
		state_nxt.lines = pins.line_level;

		// register writes
		if (REG_WR) begin
			for (int d = 0; d < NUM_DEV; d++) begin
				if (REG_ADDR == ROUTE_OFS[d]) begin
					state_nxt.route[d] = REG_WDATA[15:0] & ROUTE_MASK;
				end
			end
			// window select kept writable at any time; safe use is software's job
			if (REG_ADDR == OFS_OTHER_CTRL) begin
				state_nxt.other = REG_WDATA[7:0] & OTHER_MASK;
				if (((REG_WDATA[7:0] & OTHER_MASK) ^ state_r.other) != 8'h00) begin
					evt[EVT_CFG_CHANGE] = 1'b1;
				end
			end
			if (REG_ADDR == OFS_C3_LATENCY) begin
				state_nxt.lat = REG_WDATA & LAT_MASK;
			end
			if (REG_ADDR == OFS_EVT_MASK) begin
				state_nxt.mask = REG_WDATA[NUM_EVT-1:0];
			end
			if (REG_ADDR == OFS_FLOAT_ERROR_IN_CLEAR) begin
				f0_write = 1'b1;
			end
		end

		// coprocessor error: latch on low pin, release on port F0h write or when the enable bit is cleared
		if (!state_r.other[OTHER_CEN_BIT]) begin
			state_nxt.irq13 = 1'b0;
		end else if (float_error_in_low && !state_r.irq13) begin
			state_nxt.irq13 = 1'b1;
			evt[EVT_FLOAT_ERROR_IN]   = 1'b1;
		end else if (f0_write) begin
			state_nxt.irq13 = 1'b0;
		end

		// read data, valid the cycle after the strobe only
		state_nxt.rdata = 32'h0000_0000;
		if (REG_RD) begin
			for (int d = 0; d < NUM_DEV; d++) begin
				if (REG_ADDR == ROUTE_OFS[d]) begin
					state_nxt.rdata = {16'h0000, state_r.route[d]};
				end
			end
			case (REG_ADDR)
				OFS_DEV30_ROUTE: state_nxt.rdata = 32'h0000_0000;
				OFS_OTHER_CTRL:  state_nxt.rdata = {24'h00_0000, state_r.other};
				OFS_C3_LATENCY:  state_nxt.rdata = state_r.lat;
				OFS_EVT_STATUS:  state_nxt.rdata = {{(32-NUM_EVT){1'b0}}, state_r.status};
				OFS_EVT_MASK:    state_nxt.rdata = {{(32-NUM_EVT){1'b0}}, state_r.mask};
				default: begin
				end
			endcase
		end

		// sticky status: read clears, a same-cycle event wins
		if (REG_RD && REG_ADDR == OFS_EVT_STATUS) begin
			state_nxt.status = evt;
		end else begin
			state_nxt.status = state_r.status | evt;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			for (int d = 0; d < NUM_DEV; d++) begin
				state_r.route[d] <= ROUTE_RESET;
			end
			state_r.other     <= OTHER_RESET;
			state_r.lat       <= LAT_RESET;
			state_r.irq13     <= 1'b0;
			state_r.float_error_in_sync <= '1;
			state_r.float_error_in_seen <= 1'b0;
			state_r.status    <= '0;
			state_r.mask      <= '0;
			state_r.lines     <= '0;
			state_r.rdata     <= 32'h0000_0000;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign REG_RDATA                  = state_r.rdata;
	assign SHARED_REQ_LINE            = state_r.lines;
	assign IRQ13_OUT                  = state_r.irq13;
	assign IGNORE_NUMERIC_ERROR_OUT_N = ~state_r.irq13;
	assign IO_INTC_ENABLE             = state_r.other[OTHER_AEN_BIT];
	assign APIC_WINDOW_SELECT         = state_r.other[OTHER_SEL_LSB +: 4];
	assign LAT_C0_TO_C3               = state_r.lat[6:0];
	assign LAT_C2_TO_C3               = state_r.lat[14:8];
	assign LAT_C3_TO_C3               = state_r.lat[22:16];
	assign INTERRUPT                  = |(state_r.status & state_r.mask);
endmodule

// *** verif/iprc_chk.sv ***
// Purpose: port assertions for iprc_top
// Assumes: one clock, RST synchronous active high
// Notes:   cen_r mirrors an enable bit that has no pin
`timescale 1ns/1ps
module iprc_chk
	import iprc_pkg::*;
(
	input wire logic        REF_CLK,
	input wire logic        RST,
	input wire logic [15:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic [23:0] DEV_PIN_IN,
	input wire logic        FLOAT_ERROR_IN_N,
	input wire logic [7:0]  SHARED_REQ_LINE,
	input wire logic        IRQ13_OUT,
	input wire logic        IGNORE_NUMERIC_ERROR_OUT_N,
	input wire logic        IO_INTC_ENABLE,
	input wire logic [3:0]  APIC_WINDOW_SELECT,
	input wire logic [6:0]  LAT_C0_TO_C3,
	input wire logic [6:0]  LAT_C2_TO_C3,
	input wire logic [6:0]  LAT_C3_TO_C3
);
	logic cen_r;
	wire  clr    = REG_WR && REG_ADDR == OFS_FLOAT_ERROR_IN_CLEAR;
	wire  oic_wr = REG_WR && REG_ADDR == OFS_OTHER_CTRL;
	// mirror of the enable; lags the design by nothing
	always_ff @(posedge REF_CLK) begin
		if (RST) cen_r <= 1'b0;
		else if (oic_wr) cen_r <= REG_WDATA[OTHER_CEN_BIT];
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// six quiet cycles cover 3 sync flops, latch and a re-arm
	sequence s_armed;
		(cen_r && !FLOAT_ERROR_IN_N && !clr)[*6];
	endsequence
	a_ignore_numeric_error_out_inverse: assert property (IGNORE_NUMERIC_ERROR_OUT_N == !IRQ13_OUT)
		else $error("ignore-error output not inverse of irq13");
	a_irq_raise: assert property (s_armed |-> IRQ13_OUT)
		else $error("irq13 not raised");
	a_irq_blocked: assert property (!cen_r [*2] |-> !IRQ13_OUT)
		else $error("irq13 while disabled");
	a_irq_cause: assert property ($rose(IRQ13_OUT) |-> cen_r && !($past(FLOAT_ERROR_IN_N, 3) && $past(FLOAT_ERROR_IN_N, 4)))
		else $error("irq13 without float error");
	a_irq_hold: assert property (IRQ13_OUT && !clr && !oic_wr |=> IRQ13_OUT)
		else $error("irq13 dropped");
	// a clear that meets an unlatched, still-low error re-arms, so only a standing irq is checked
	a_irq_clear: assert property (clr && IRQ13_OUT |=> !IRQ13_OUT)
		else $error("irq13 not cleared");
	a_bridge_zero: assert property ($past(REG_RD && REG_ADDR == OFS_DEV30_ROUTE) |-> REG_RDATA == 32'h0)
		else $error("bridge route not zero");
	a_route_rsv: assert property ($past(REG_RD && REG_ADDR >= OFS_DEV31_ROUTE && REG_ADDR <= OFS_DEV25_ROUTE)
		|-> (REG_RDATA & ~32'h7777) == 32'h0)
		else $error("route reserved bits set");
	a_ctrl_follow: assert property (oic_wr |=> IO_INTC_ENABLE == $past(REG_WDATA[0])
		&& APIC_WINDOW_SELECT == $past(REG_WDATA[7:4]))
		else $error("control outputs wrong");
	a_lat_follow: assert property (REG_WR && REG_ADDR == OFS_C3_LATENCY |=> LAT_C0_TO_C3 == $past(REG_WDATA[6:0])
		&& LAT_C2_TO_C3 == $past(REG_WDATA[14:8]) && LAT_C3_TO_C3 == $past(REG_WDATA[22:16]))
		else $error("latency outputs wrong");
	a_lines_idle: assert property ($past(DEV_PIN_IN) == 24'h0 |-> SHARED_REQ_LINE == 8'h0)
		else $error("line high with no pin");
endmodule
bind iprc_top iprc_chk i_chk (.*);

// *** verif/iprc_far_model.sv ***
// Purpose: device functions and numeric error source
// Assumes: requests come from the bench
// Notes:   error line idles high
`timescale 1ns/1ps
module iprc_far_model (
	input  wire logic        clk,
	input  wire logic [23:0] pin_req,
	input  wire logic        float_error_in_req,
	output logic      [23:0] dev_pin = 24'h0,
	output logic             float_error_in_n = 1'b1
);
	// registered, so pins move just after an edge
	always @(posedge clk) begin
		dev_pin <= pin_req;
		float_error_in_n  <= !float_error_in_req;
	end
endmodule

// *** verif/tb_iprc_top.sv ***
// Purpose: self-checking bench for iprc_top
// Assumes: 100 MHz clock, bus driven by non-blocking writes
// Notes:   read answers checked from a queue of notes
`timescale 1ns/1ps
module tb_iprc_top;
	import iprc_pkg::*;
	logic        REF_CLK = 1'b0;
	logic        RST = 1'b1;
	logic [15:0] REG_ADDR = 16'h0;
	logic [31:0] REG_WDATA = 32'h0;
	logic        REG_WR = 1'b0;
	logic        REG_RD = 1'b0;
	logic [23:0] pin_req = 24'h0;
	logic        float_error_in_req = 1'b0;
	logic        rd_d = 1'b0;
	logic [31:0] REG_RDATA;
	logic [31:0] seed = 32'h97492cd0;
	logic [31:0] exp_q[$];
	logic [23:0] DEV_PIN_IN;
	logic [7:0]  SHARED_REQ_LINE;
	logic [6:0]  LAT_C0_TO_C3, LAT_C2_TO_C3, LAT_C3_TO_C3;
	logic [3:0]  APIC_WINDOW_SELECT, oth;
	logic        FLOAT_ERROR_IN_N, IRQ13_OUT, IGNORE_NUMERIC_ERROR_OUT_N, IO_INTC_ENABLE, INTERRUPT;
	logic [15:0] w;
	logic [15:0] ofs[6] = '{OFS_DEV25_ROUTE, OFS_DEV26_ROUTE, OFS_DEV27_ROUTE,
		OFS_DEV28_ROUTE, OFS_DEV29_ROUTE, OFS_DEV31_ROUTE};
	int          error_cnt = 0, compares = 0, d, p, c;
	always #5 REF_CLK = !REF_CLK;
	iprc_far_model i_far (.clk(REF_CLK), .pin_req, .float_error_in_req, .dev_pin(DEV_PIN_IN), .float_error_in_n(FLOAT_ERROR_IN_N));
	iprc_top i_dut (.*);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] dat);
		@(posedge REF_CLK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= dat;
		@(posedge REF_CLK);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge REF_CLK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge REF_CLK);
		REG_RD <= 1'b0;
	endtask
	// mid-cycle sampling keeps clear of the launching edge
	task automatic wt(input int n);
		repeat (n) @(posedge REF_CLK);
		@(negedge REF_CLK);
	endtask
	task automatic end_of_test;
		if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// read answers stand one cycle only, so take them then
	always @(posedge REF_CLK) rd_d <= REG_RD;
	always @(negedge REF_CLK) begin
		if (rd_d) cmp(REG_RDATA, exp_q.pop_front());
	end
	// whole run is somewhat over a thousand cycles
	initial begin
		#200us;
		error_cnt++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge REF_CLK);
		RST <= 1'b0;
		// reset values and a hole, then random writes
		for (d = 0; d < 6; d++) rd(ofs[d], 32'h3210);
		rd(OFS_DEV30_ROUTE, 32'h0);
		rd(OFS_C3_LATENCY, 32'h0);
		rd(16'h3154, 32'h0);
		for (d = 0; d < 6; d++) begin
			seed = lfsr(seed);
			wr(ofs[d], seed);
			rd(ofs[d], seed & 32'h7777);
		end
		wr(OFS_DEV30_ROUTE, 32'hffff);
		rd(OFS_DEV30_ROUTE, 32'h0);
		// each code in each field; extra pins of the device land on a second line
		for (d = 0; d < 6; d++) for (p = 0; p < 4; p++) for (c = 0; c < 8; c++) begin
			seed = lfsr(seed);
			w = {4{1'b0, 3'(c + 1)}};
			w[4 * p +: 3] = 3'(c);
			wr(ofs[d], {16'h0, w});
			oth = seed[3:0] & ~(4'h1 << p);
			pin_req <= 24'(oth | (4'h1 << p)) << (4 * d);
			wt(3);
			cmp(SHARED_REQ_LINE, (32'h1 << c) | ((oth != 4'h0) ? (32'h1 << ((c + 1) % 8)) : 32'h0));
			@(posedge REF_CLK);
			pin_req <= 24'h0;
		end
		// select moved only while the controller is off, read back after enabling
		wr(OFS_OTHER_CTRL, 32'hf0);
		wr(OFS_OTHER_CTRL, 32'hff);
		rd(OFS_OTHER_CTRL, 32'hf3);
		wt(0);
		cmp({APIC_WINDOW_SELECT, IO_INTC_ENABLE}, 32'h1f);
		rd(OFS_EVT_STATUS, 32'h2);
		wr(OFS_OTHER_CTRL, 32'hf0);
		wr(OFS_OTHER_CTRL, 32'h0);
		wr(OFS_C3_LATENCY, 32'hffffffff);
		rd(OFS_C3_LATENCY, 32'h007f7f7f);
		wt(0);
		cmp({LAT_C3_TO_C3, 1'b0, LAT_C2_TO_C3, 1'b0, LAT_C0_TO_C3}, 32'h7f7f7f);
		rd(OFS_EVT_STATUS, 32'h2);
		// float error: ignored while disabled, then latched and held
		float_error_in_req <= 1'b1;
		wt(8);
		cmp({IRQ13_OUT, IGNORE_NUMERIC_ERROR_OUT_N, INTERRUPT}, 32'h2);
		wr(OFS_EVT_MASK, 32'h1);
		wr(OFS_OTHER_CTRL, 32'h2);
		wt(6);
		cmp({IRQ13_OUT, IGNORE_NUMERIC_ERROR_OUT_N, INTERRUPT}, 32'h5);
		@(posedge REF_CLK);
		float_error_in_req <= 1'b0;
		wt(6);
		cmp(IRQ13_OUT, 32'h1);
		rd(OFS_EVT_STATUS, 32'h3);
		wr(OFS_FLOAT_ERROR_IN_CLEAR, 32'h0);
		wt(0);
		cmp({IRQ13_OUT, INTERRUPT}, 32'h0);
		end_of_test();
	end
endmodule
